// >>> src/atdp_top.sv
// transient debounce counter and pulse detector configuration
`timescale 1ns/1ps
`include "atdp_map.svh"
module atdp_top #(
  parameter int STEP_BASE_CYC = `ATDP_STEP_BASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave, word index address
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // transient threshold result, any enabled axis
  input wire logic trans_cond,
  // pulse detector results, bit 0 x, 1 y, 2 z
  input wire logic [2:0] single_pulse,
  input wire logic [2:0] double_pulse,
  input wire logic [2:0] pulse_pol,
  // latency window tracking
  input wire logic ltcy_window,
  input wire logic pulse_start,
  input wire logic pulse_end,
  // status out
  output logic trans_flag,
  output logic pulse_event_flag,
  output logic double_detect_en,
  output logic irq
);
  import atdp_pkg::*;

  atdp_byte_t debounce_count_value;
  atdp_byte_t pulse_cfg;
  atdp_byte_t pulse_src;
  atdp_byte_t mode_reg;
  atdp_byte_t tr_ctrl;
  atdp_byte_t dbc_cnt;
  atdp_byte_t next_dbc_cnt;
  atdp_byte_t rd_mux;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  logic [2:0] irq_events;
  logic [2:0] irq_clr;
  logic [2:0] sp_hit;
  logic [2:0] dp_hit;
  logic ack;
  logic req;
  logic wr_acc;
  logic src_read;
  logic step;
  logic pulse_hit;
  logic trans_event;
  logic started_in_win;
  logic dbl_suppress;
  logic abort_event;
  logic cnt_mode;

  ////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then accept

  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack;
  assign wr_acc = avs_write && ack;
  assign src_read = avs_read && ack && (avs_address == `ATDP_IDX_PULSE_SRC);
  assign irq_clr = (wr_acc && avs_address == `ATDP_IDX_IRQ_CLR) ?
                   avs_writedata[2:0] : 3'h0;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end

  always_comb begin
    unique case (avs_address)
      `ATDP_IDX_DEBOUNCE_COUNT_VALUE: rd_mux = debounce_count_value;
      `ATDP_IDX_PULSE_CFG: rd_mux = pulse_cfg;
      `ATDP_IDX_PULSE_SRC: rd_mux = pulse_src;
      `ATDP_IDX_MODE: rd_mux = mode_reg;
      `ATDP_IDX_TR_CTRL: rd_mux = tr_ctrl;
      `ATDP_IDX_TR_STAT: rd_mux = dbc_cnt;
      `ATDP_IDX_IRQ_STAT: rd_mux = {5'h00, irq_stat};
      `ATDP_IDX_IRQ_EN: rd_mux = {5'h00, irq_en};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data captured in the wait cycle, stands at the accepting edge
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack) begin
      avs_readdata <= {23'h000000, (avs_address == `ATDP_IDX_TR_STAT) &&
                       trans_flag, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge clk) begin
    if (srst) begin
      debounce_count_value <= `ATDP_RST_DEBOUNCE_COUNT_VALUE;
    end else if (wr_acc && avs_address == `ATDP_IDX_DEBOUNCE_COUNT_VALUE) begin
      debounce_count_value <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pulse_cfg <= `ATDP_RST_PULSE_CFG;
    end else if (wr_acc && avs_address == `ATDP_IDX_PULSE_CFG) begin
      pulse_cfg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= `ATDP_RST_MODE;
      tr_ctrl <= `ATDP_RST_TR_CTRL;
      irq_en <= `ATDP_RST_IRQ;
    end else if (wr_acc) begin
      if (avs_address == `ATDP_IDX_MODE) begin
        mode_reg <= avs_writedata[7:0];
      end
      if (avs_address == `ATDP_IDX_TR_CTRL) begin
        tr_ctrl <= avs_writedata[7:0];
      end
      if (avs_address == `ATDP_IDX_IRQ_EN) begin
        irq_en <= avs_writedata[2:0];
      end
    end
  end

  assign cnt_mode = tr_ctrl[`ATDP_TRCTRL_DBCNTM];

  ////////////////////////////////////////////////////////////////////////
  // transient debounce

  atdp_step_timer #(
    .BASE_CYC(STEP_BASE_CYC)
  ) u_step (
    .clk(clk),
    .srst(srst),
    .odr(mode_reg[`ATDP_MODE_ODR_LSB +: 3]),
    .pwr(atdp_pwr_e'(mode_reg[`ATDP_MODE_PWR_LSB +: 2])),
    .hybrid(mode_reg[`ATDP_MODE_HYB]),
    .step(step)
  );

  always_comb begin
    next_dbc_cnt = dbc_cnt;
    if (trans_cond) begin
      if (dbc_cnt != 8'hFF) begin
        next_dbc_cnt = dbc_cnt + 8'h01;
      end
    end else if (cnt_mode) begin
      next_dbc_cnt = 8'h00;
    end else if (dbc_cnt != 8'h00) begin
      next_dbc_cnt = dbc_cnt - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dbc_cnt <= 8'h00;
    end else if (step) begin
      dbc_cnt <= next_dbc_cnt;
    end
  end

  // flag on a step with true condition once the counter reaches count
  assign trans_event = step && trans_cond && !trans_flag &&
                       (next_dbc_cnt >= debounce_count_value);

  always_ff @(posedge clk) begin
    if (srst) begin
      trans_flag <= 1'b0;
    end else if (step) begin
      trans_flag <= trans_cond && (next_dbc_cnt >= debounce_count_value);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // double-pulse abort

  always_ff @(posedge clk) begin
    if (srst || !ltcy_window) begin
      started_in_win <= 1'b0;
    end else if (pulse_start) begin
      started_in_win <= 1'b1;
    end
  end

  assign abort_event = pulse_cfg[`ATDP_PCFG_DPA] && ltcy_window &&
                       pulse_end && (started_in_win || pulse_start) &&
                       !dbl_suppress;

  always_ff @(posedge clk) begin
    if (srst || !ltcy_window) begin
      dbl_suppress <= 1'b0;
    end else if (abort_event) begin
      dbl_suppress <= 1'b1;
    end
  end

  assign double_detect_en = !dbl_suppress;

  ////////////////////////////////////////////////////////////////////////
  // pulse enables and source

  for (genvar i = 0; i < 3; i++) begin : g_axis
    assign sp_hit[i] = single_pulse[i] && pulse_cfg[2*i];
    assign dp_hit[i] = double_pulse[i] && pulse_cfg[2*i+1] &&
                       !dbl_suppress;
  end

  assign pulse_hit = |(sp_hit | dp_hit);

  // new event wins over a read in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pulse_src <= 8'h00;
    end else if (pulse_hit && (!pulse_cfg[`ATDP_PCFG_ELE] ||
                 !pulse_src[`ATDP_SRC_EA] || src_read)) begin
      pulse_src <= {1'b1, sp_hit | dp_hit, |dp_hit, pulse_pol};
    end else if (src_read) begin
      pulse_src <= 8'h00;
    end
  end

  assign pulse_event_flag = pulse_src[`ATDP_SRC_EA];

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over clear

  assign irq_events = {abort_event, pulse_hit, trans_event};

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat <= `ATDP_RST_IRQ;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_events;
    end
  end

  assign irq = |(irq_stat & irq_en);

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_DBC_CLEAR: assert property (
    step && !trans_cond && cnt_mode |=> dbc_cnt == 8'h00)
    else $error("counter not cleared");

  AST_DBC_DEC: assert property (
    step && !trans_cond && !cnt_mode && dbc_cnt != 8'h00
    |=> dbc_cnt == $past(dbc_cnt) - 8'h01)
    else $error("counter not decremented");

  AST_DBC_INC: assert property (
    step && trans_cond && dbc_cnt != 8'hFF
    |=> dbc_cnt == $past(dbc_cnt) + 8'h01)
    else $error("counter not incremented");

  AST_TR_FLAG: assert property (
    $rose(trans_flag) |-> dbc_cnt >= debounce_count_value)
    else $error("transient flag before count reached");

  AST_NO_STRAY_SRC: assert property (
    !pulse_hit && !src_read |=> $stable(pulse_src))
    else $error("pulse source changed without enabled event");

  AST_SRC_LATCH: assert property (
    pulse_cfg[`ATDP_PCFG_ELE] && pulse_src[`ATDP_SRC_EA] && !src_read
    |=> pulse_src == $past(pulse_src))
    else $error("latched pulse source changed");

  AST_DPE: assert property (
    pulse_hit && (!pulse_cfg[`ATDP_PCFG_ELE] || !pulse_src[`ATDP_SRC_EA] ||
                  src_read)
    |=> pulse_src[`ATDP_SRC_DPE] == $past(|dp_hit))
    else $error("double pulse bit wrong");

  AST_ABORT: assert property (
    pulse_cfg[`ATDP_PCFG_DPA] && ltcy_window && pulse_end &&
    $past(pulse_start) && $past(ltcy_window)
    ##1 ltcy_window |-> !double_detect_en)
    else $error("double detection not suspended");

  AST_NO_ABORT: assert property (
    !pulse_cfg[`ATDP_PCFG_DPA] && double_detect_en |=> double_detect_en)
    else $error("double detection stopped without abort");

  AST_RESET_VAL: assert property (
    $past(srst) |-> debounce_count_value == 8'h00 && pulse_cfg == 8'h00)
    else $error("config not zero after reset");

  AST_BUS_WAIT: assert property (
    avs_waitrequest |=> !req || !avs_waitrequest)
    else $error("waitrequest held too long");
endmodule

// >>> inc/atdp_map.svh
// register map, field positions, reset values and timing counts
`ifndef ATDP_MAP_SVH
`define ATDP_MAP_SVH

// register indices, byte address is four times the index
`define ATDP_IDX_DEBOUNCE_COUNT_VALUE 8'h20
`define ATDP_IDX_PULSE_CFG 8'h21
`define ATDP_IDX_PULSE_SRC 8'h22
`define ATDP_IDX_MODE 8'h30
`define ATDP_IDX_TR_CTRL 8'h31
`define ATDP_IDX_TR_STAT 8'h32
`define ATDP_IDX_IRQ_STAT 8'h33
`define ATDP_IDX_IRQ_EN 8'h34
`define ATDP_IDX_IRQ_CLR 8'h35

// reset values
`define ATDP_RST_DEBOUNCE_COUNT_VALUE 8'h00
`define ATDP_RST_PULSE_CFG 8'h00
`define ATDP_RST_MODE 8'h00
`define ATDP_RST_TR_CTRL 8'h00
`define ATDP_RST_IRQ 3'h0

// fields
`define ATDP_PCFG_DPA 7
`define ATDP_PCFG_ELE 6
`define ATDP_SRC_EA 7
`define ATDP_SRC_AX_LSB 4
`define ATDP_SRC_DPE 3
`define ATDP_SRC_POL_LSB 0
`define ATDP_MODE_ODR_LSB 0
`define ATDP_MODE_PWR_LSB 4
`define ATDP_MODE_HYB 6
`define ATDP_TRCTRL_DBCNTM 7
`define ATDP_TRSTAT_FLAG 8
`define ATDP_IRQ_TR 0
`define ATDP_IRQ_PLS 1
`define ATDP_IRQ_ABT 2

// timing
`define ATDP_CLK_NS 10
`define ATDP_STEP_BASE_NS 1250000
`define ATDP_STEP_BASE_CYC (`ATDP_STEP_BASE_NS / `ATDP_CLK_NS)
// step exponent caps: 20 ms, 80 ms, 2.5 ms, 160 ms
`define ATDP_CAP_NORMAL 4'h4
`define ATDP_CAP_LOW_NOISE_LOW_POWER_MODE 4'h6
`define ATDP_CAP_HIRES 4'h1
`define ATDP_CAP_LP 4'h7

`endif

// >>> inc/atdp_pkg.sv
// types shared by the transient debounce and pulse configuration block
package atdp_pkg;
  typedef enum logic [1:0] {
    ATDP_PWR_NORMAL = 2'h0,
    ATDP_PWR_LOW_NOISE_LOW_POWER_MODE = 2'h1,
    ATDP_PWR_HIRES = 2'h2,
    ATDP_PWR_LP = 2'h3
  } atdp_pwr_e;
  typedef logic [7:0] atdp_byte_t;
endpackage

// >>> src/atdp_step_timer.sv
// debounce time step tick generator
`timescale 1ns/1ps
`include "atdp_map.svh"
module atdp_step_timer #(
  parameter int BASE_CYC = `ATDP_STEP_BASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // rate and mode
  input wire logic [2:0] odr,
  input wire atdp_pkg::atdp_pwr_e pwr,
  input wire logic hybrid,
  // one-cycle tick per debounce step
  output logic step
);
  import atdp_pkg::*;

  localparam int BW = $clog2(BASE_CYC + 1);
  localparam logic [BW-1:0] BASE_LAST = BW'(BASE_CYC - 1);

  logic [BW-1:0] base_cnt;
  logic [8:0] unit_cnt;
  logic [3:0] rate_exp;
  logic [3:0] cap;
  logic [3:0] step_exp;
  logic [8:0] units_last;
  logic base_wrap;

  ////////////////////////////////////////////////////////////////////////
  // rate doublings below 800 Hz, clipped by the power mode cap
  always_comb begin
    unique case (odr)
      3'h0: rate_exp = 4'h0;
      3'h1: rate_exp = 4'h1;
      3'h2: rate_exp = 4'h2;
      3'h3: rate_exp = 4'h3;
      3'h4: rate_exp = 4'h4;
      3'h5: rate_exp = 4'h6;
      3'h6: rate_exp = 4'h7;
      3'h7: rate_exp = 4'h9;
    endcase
    unique case (pwr)
      ATDP_PWR_NORMAL: cap = `ATDP_CAP_NORMAL;
      ATDP_PWR_LOW_NOISE_LOW_POWER_MODE: cap = `ATDP_CAP_LOW_NOISE_LOW_POWER_MODE;
      ATDP_PWR_HIRES: cap = `ATDP_CAP_HIRES;
      ATDP_PWR_LP: cap = `ATDP_CAP_LP;
    endcase
    step_exp = (rate_exp < cap) ? rate_exp : cap;
    if (hybrid) begin
      step_exp = step_exp + 4'h1;
    end
    units_last = (9'h001 << step_exp) - 9'h001;
  end

  assign base_wrap = (base_cnt >= BASE_LAST);

  ////////////////////////////////////////////////////////////////////////
  // base 1.25 ms period
  always_ff @(posedge clk) begin
    if (srst || base_wrap) begin
      base_cnt <= '0;
    end else begin
      base_cnt <= base_cnt + BW'(1);
    end
  end

  // units of base period per step, follows live mode
  always_ff @(posedge clk) begin
    if (srst) begin
      unit_cnt <= 9'h000;
    end else if (base_wrap) begin
      unit_cnt <= (unit_cnt >= units_last) ? 9'h000 : unit_cnt + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      step <= 1'b0;
    end else begin
      step <= base_wrap && (unit_cnt >= units_last);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_STEP_SPACING: assert property (
    step |=> !step [*2]) else $error("step ticks too close");
endmodule

// >>> dv/atdp_top_bench.sv
// self-checking bench for the transient debounce and pulse config block
`timescale 1ns/1ps
`include "atdp_map.svh"
module atdp_top_bench;
  import atdp_pkg::*;
  localparam int BASE = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic trans_cond = 1'b0;
  logic [2:0] single_pulse = 3'h0;
  logic [2:0] double_pulse = 3'h0;
  logic [2:0] pulse_pol = 3'h0;
  logic ltcy_window = 1'b0;
  logic pulse_start = 1'b0;
  logic pulse_end = 1'b0;
  logic trans_flag;
  logic pulse_event_flag;
  logic double_detect_en;
  logic irq;
  int n_fail = 0;
  int checked = 0;

  atdp_top #(.STEP_BASE_CYC(BASE)) i_dut (
    .clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trans_cond(trans_cond),
    .single_pulse(single_pulse), .double_pulse(double_pulse),
    .pulse_pol(pulse_pol), .ltcy_window(ltcy_window),
    .pulse_start(pulse_start), .pulse_end(pulse_end),
    .trans_flag(trans_flag), .pulse_event_flag(pulse_event_flag),
    .double_detect_en(double_detect_en), .irq(irq)
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_up(input string what);
    n_fail++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    print_verdict();
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk);
    avs_address <= idx;
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) give_up("bus");
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, d, rd);
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx,
                       input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 8'h00, rd);
    chk(what, rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  function automatic int step_cyc(input logic [7:0] m);
    int rexp[8] = '{0, 1, 2, 3, 4, 6, 7, 9};
    int cap[4] = '{4, 6, 1, 7};
    int e;
    e = rexp[m[2:0]];
    if (e > cap[m[5:4]]) e = cap[m[5:4]];
    return (BASE << e) << m[6];
  endfunction

  task automatic wait_tf(input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (trans_flag !== v && n < 5000);
    if (trans_flag !== v) give_up("trans_flag wait");
  endtask

  // cycles from a dropped flag to the next rise with condition held
  task automatic measure(input logic [7:0] m, input logic [7:0] ctl,
                         input logic [7:0] cnt, input int k);
    int n;
    wr(`ATDP_IDX_MODE, m);
    wr(`ATDP_IDX_TR_CTRL, ctl);
    wr(`ATDP_IDX_DEBOUNCE_COUNT_VALUE, cnt);
    trans_cond <= 1'b1;
    wait_tf(1'b1, n);
    trans_cond <= 1'b0;
    wait_tf(1'b0, n);
    trans_cond <= 1'b1;
    wait_tf(1'b1, n);
    chk("debounce cycles", n, k * step_cyc(m));
    trans_cond <= 1'b0;
    wait_tf(1'b0, n);
    if (ctl[7]) begin
      rdchk("tr status cleared", `ATDP_IDX_TR_STAT, 32'h0);
    end
  endtask

  task automatic hit(input logic [2:0] s, input logic [2:0] d,
                     input logic [2:0] p);
    @(posedge clk);
    single_pulse <= s;
    double_pulse <= d;
    pulse_pol <= p;
    @(posedge clk);
    single_pulse <= 3'h0;
    double_pulse <= 3'h0;
    @(posedge clk);
  endtask

  task automatic window_pulse();
    @(posedge clk);
    ltcy_window <= 1'b1;
    pulse_start <= 1'b1;
    @(posedge clk);
    pulse_start <= 1'b0;
    pulse_end <= 1'b1;
    @(posedge clk);
    pulse_end <= 1'b0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] tm[9] = '{8'h00, 8'h00, 8'h04, 8'h05, 8'h15, 8'h23,
                          8'h37, 8'h42, 8'h40};
    logic [7:0] tc[9] = '{8'h80, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80,
                          8'h80, 8'h80, 8'h80};
    int tk[9] = '{3, 1, 1, 1, 1, 1, 1, 1, 2};
    logic [2:0] ax;
    logic dbl;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rdchk("count reset", `ATDP_IDX_DEBOUNCE_COUNT_VALUE, 32'h0);
    rdchk("pulse cfg reset", `ATDP_IDX_PULSE_CFG, 32'h0);
    chk("detect en reset", double_detect_en, 32'h1);
    wr(`ATDP_IDX_DEBOUNCE_COUNT_VALUE, 8'hA5);
    rdchk("count rw", `ATDP_IDX_DEBOUNCE_COUNT_VALUE, 32'hA5);
    wr(`ATDP_IDX_PULSE_CFG, 8'h5A);
    rdchk("pulse cfg rw", `ATDP_IDX_PULSE_CFG, 32'h5A);
    rdchk("unmapped", 8'h10, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 9; i++) begin
      measure(tm[i], tc[i], tm[i] == 8'h00 ? 8'h03 : tk[i][7:0], tk[i]);
    end
    $display("test debounce done");
    rdchk("irq stat", `ATDP_IDX_IRQ_STAT, 32'h1);
    @(posedge clk);
    chk("irq masked", irq, 32'h0);
    wr(`ATDP_IDX_IRQ_EN, 8'h07);
    @(posedge clk);
    chk("irq on", irq, 32'h1);
    wr(`ATDP_IDX_IRQ_CLR, 8'h07);
    @(posedge clk);
    chk("irq cleared", irq, 32'h0);
    rdchk("irq clr reads", `ATDP_IDX_IRQ_CLR, 32'h0);
    $display("test interrupt done");
    for (int b = 0; b < 6; b++) begin
      ax = 3'b001 << (b / 2);
      dbl = b[0];
      wr(`ATDP_IDX_PULSE_CFG, 8'h01 << b);
      hit(dbl ? 3'h7 : ~ax, dbl ? ~ax : 3'h7, ax);
      chk("flag other kind", pulse_event_flag, 32'h0);
      hit(dbl ? 3'h0 : ax, dbl ? ax : 3'h0, ax);
      chk("flag enabled", pulse_event_flag, 32'h1);
      rdchk("pulse src", `ATDP_IDX_PULSE_SRC, {1'b1, ax, dbl, ax});
      @(posedge clk);
      chk("flag after read", pulse_event_flag, 32'h0);
    end
    $display("test pulse enables done");
    wr(`ATDP_IDX_PULSE_CFG, 8'h45);
    hit(3'b001, 3'h0, 3'b001);
    hit(3'b010, 3'h0, 3'b000);
    repeat (5) @(posedge clk);
    chk("latched flag", pulse_event_flag, 32'h1);
    rdchk("latched src", `ATDP_IDX_PULSE_SRC, 32'h91);
    wr(`ATDP_IDX_PULSE_CFG, 8'h05);
    hit(3'b001, 3'h0, 3'b001);
    hit(3'b010, 3'h0, 3'b000);
    rdchk("unlatched src", `ATDP_IDX_PULSE_SRC, 32'hA0);
    $display("test latch done");
    wr(`ATDP_IDX_PULSE_CFG, 8'h82);
    window_pulse();
    chk("abort detect en", double_detect_en, 32'h0);
    hit(3'h0, 3'b001, 3'h0);
    chk("aborted double", pulse_event_flag, 32'h0);
    rdchk("abort irq stat", `ATDP_IDX_IRQ_STAT, 32'h6);
    ltcy_window <= 1'b0;
    repeat (2) @(posedge clk);
    chk("detect en back", double_detect_en, 32'h1);
    wr(`ATDP_IDX_PULSE_CFG, 8'h02);
    window_pulse();
    chk("no abort detect en", double_detect_en, 32'h1);
    hit(3'h0, 3'b001, 3'h0);
    chk("double kept", pulse_event_flag, 32'h1);
    rdchk("double src", `ATDP_IDX_PULSE_SRC, 32'h98);
    ltcy_window <= 1'b0;
    $display("test abort done");
    print_verdict();
  end
endmodule
